// *** hdl/led_bank_params.svh ***
/*
  Named constants of the LED bank dimming and fault logic: register offsets, field positions,
  reset values and timing figures.
  Assumes it is included by its bare name and that mclk runs at 50 MHz.
*/
`ifndef LED_BANK_PARAMS_SVH
`define LED_BANK_PARAMS_SVH

// Clock and timing figures.
`define MCLK_PERIOD_NS      20
`define OPEN_DEG_TIME_MS    2
`define OPEN_DEG_CYCLES     ((`OPEN_DEG_TIME_MS * 1000000) / `MCLK_PERIOD_NS)
`define OPEN_CNT_W          17
`define OPEN_DIM_CYCLES     3'h7
`define DIM_CNT_W           3

// Register byte offsets.
`define AXI_AW              4
`define REG_CTRL            4'h0
`define REG_STATE           4'h4
`define REG_INT_STATUS      4'h8
`define REG_INT_MASK        4'hc

// Control register fields and reset value.
`define CTRL_ENABLE_BIT     0
`define CTRL_RESET          32'h0000_0001

// State register fields.
`define ST_LINE_BIT         0
`define ST_DRIVE_BIT        1
`define ST_TSD_BIT          2
`define ST_FOLD_BIT         3
`define ST_REFSHORT_BIT     4
`define ST_BOOST_BIT        5
`define ST_SHORT_LSB        8
`define ST_OPEN_LSB         16
`define ST_CHON_LSB         24

// Interrupt status and mask fields.
`define INT_W               7
`define INT_SHORT_BIT       0
`define INT_OPEN_BIT        1
`define INT_TSD_BIT         2
`define INT_FOLD_BIT        3
`define INT_REFSHORT_BIT    4
`define INT_LINE_LOW_BIT    5
`define INT_CLEARED_BIT     6
`define INT_MASK_RESET      7'h00

// Bus responses.
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// *** hdl/led_bank_pkg.sv ***
/*
  Types shared by the LED bank dimming and fault logic.
  Assumes nothing beyond a SystemVerilog compiler; users write led_bank_pkg::name.
*/
package led_bank_pkg;

  // Tracker for an external clearing toggle on the shared fault line.
  typedef enum logic [1:0] {
    CLR_IDLE = 2'b00,  // Waiting for proof that someone outside holds the line high.
    CLR_HELD = 2'b01,  // Line seen high while this device pulls it low.
    CLR_LOW  = 2'b10   // Line then seen low; a return to high completes the toggle.
  } clr_state_t;

endpackage : led_bank_pkg

// *** hdl/led_bank_ctrl.sv ***
/*
  Control and diagnostic logic of an eight-channel linear LED driver: bank dimming gates, level
  select, fault detection with latched and self-clearing reactions, the open-drain shared fault
  line, and an AXI4-Lite register slave with a masked interrupt.
  Assumes every input is synchronous to mclk, analog comparators arrive as ready-made levels,
  and the fault pin is resolved outside from fault_out and fault_oe_n with a weak pull-up.
*/
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "led_bank_params.svh"

module led_bank_ctrl #(
  parameter int OPEN_DEG_CYCLES = `OPEN_DEG_CYCLES  // Full-on open-load deglitch length.
) (
  input  wire logic                mclk,
  input  wire logic                rst,
  input  wire logic                dim_bank_input_1,
  input  wire logic                dim_bank_input_2,
  input  wire logic                dim_bank_input_3,
  input  wire logic                dim_bank_input_4,
  input  wire logic                level_select,
  input  wire logic                chip_activate,
  input  wire logic [7:0]          short_detect,
  input  wire logic [7:0]          headroom_low,
  input  wire logic                temp_shutdown_hot,
  input  wire logic                temp_shutdown_cool,
  input  wire logic                temp_foldback_hot,
  input  wire logic                temp_foldback_cool,
  input  wire logic                ref_resistor_short,
  input  wire logic                fault_in,
  output logic                     fault_out,
  output logic                     fault_oe_n,
  output logic [7:0]               led_channel_en,
  output logic                     boost_current_setpoint,
  output logic                     foldback_active,
  output logic                     irq,
  input  wire logic [`AXI_AW-1:0]  s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [`AXI_AW-1:0]  s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready
);

  // Checks that a byte offset names a register of this block.
  function automatic logic reg_mapped(input logic [`AXI_AW-1:0] addr);
    reg_mapped = (addr == `REG_CTRL) || (addr == `REG_STATE) ||
                 (addr == `REG_INT_STATUS) || (addr == `REG_INT_MASK);
  endfunction : reg_mapped

  logic [3:0]             bank;            // Dimming inputs gathered by bank number.
  logic [3:0]             bank_prev_ff;    // Dimming inputs one cycle ago, for rising edges.
  logic [7:0]             short_lat_ff;    // Latched output-short faults per channel.
  logic [7:0]             open_conf_ff;    // Confirmed open-load faults per channel.
  logic [7:0]             short_set;       // Channels whose short is caught this cycle.
  logic                   tsd_ff;          // Thermal shutdown in force.
  logic                   fold_ff;         // Thermal foldback in force.
  logic                   refshort_ff;     // Latched reference-resistor short.
  logic                   boost_ff;        // Registered level select.
  logic                   act_prev_ff;     // Chip-activate one cycle ago.
  logic                   line_prev_ff;    // Fault line level one cycle ago.
  logic [7:0]             chan_ff;         // Registered channel enables.
  logic [7:0]             nxt_chan;        // Channel enables computed this cycle.
  logic                   drive_low;       // This device pulls the fault line low.
  logic                   act_toggle;      // Chip-activate edge seen.
  logic                   line_toggle;     // External clearing toggle completed.
  logic                   clr_latch;       // Clears short latches.
  logic [31:0]            ctrl_ff;         // Control register.
  logic [`INT_W-1:0]      int_sts_ff;      // Sticky interrupt status.
  logic [`INT_W-1:0]      int_mask_ff;     // Interrupt enable mask.
  logic [`INT_W-1:0]      events;          // One-cycle event pulses.
  logic [`INT_W-1:0]      w1c;             // Bits that software clears this cycle.
  logic                   tsd_prev_ff;     // Edge trackers for level-type events.
  logic                   fold_prev_ff;
  logic                   ref_prev_ff;
  logic [7:0]             open_prev_ff;    // Open confirmations one cycle ago.
  led_bank_pkg::clr_state_t clr_ff;        // External toggle tracker.
  logic                   aw_ff;           // Write address held.
  logic [`AXI_AW-1:0]     awaddr_ff;
  logic                   w_ff;            // Write data held.
  logic [31:0]            wdata_ff;
  logic [3:0]             wstrb_ff;
  logic                   wr_go;           // Both halves of a write present.
  logic [31:0]            rd_word;         // Read multiplexer output.

  assign bank = {dim_bank_input_4, dim_bank_input_3, dim_bank_input_2, dim_bank_input_1};

  // Edge trackers for activate, line, bank inputs and level events.
  always_ff @(posedge mclk) begin
    if (rst) begin
      bank_prev_ff <= 4'h0;
      act_prev_ff  <= chip_activate;
      line_prev_ff <= 1'b1;
      tsd_prev_ff  <= 1'b0;
      fold_prev_ff <= 1'b0;
      ref_prev_ff  <= 1'b0;
      open_prev_ff <= 8'h00;
    end else begin
      bank_prev_ff <= bank;
      act_prev_ff  <= chip_activate;
      line_prev_ff <= fault_in;
      tsd_prev_ff  <= tsd_ff;
      fold_prev_ff <= fold_ff;
      ref_prev_ff  <= refshort_ff;
      open_prev_ff <= open_conf_ff;
    end
  end

  // Any change of chip-activate counts as a toggle, so a pulse either way releases the latches.
  assign act_toggle = chip_activate ^ act_prev_ff;

  // The first high must be seen while this device pulls low, which only an outside party can
  // cause; this keeps our own assert and release of the line from clearing our own latch.
  always_ff @(posedge mclk) begin
    if (rst) begin
      clr_ff <= led_bank_pkg::CLR_IDLE;
    end else begin
      case (clr_ff)
        led_bank_pkg::CLR_IDLE: begin
          if (drive_low && fault_in) begin
            clr_ff <= led_bank_pkg::CLR_HELD;
          end
        end
        led_bank_pkg::CLR_HELD: begin
          if (!fault_in) begin
            clr_ff <= led_bank_pkg::CLR_LOW;
          end
        end
        led_bank_pkg::CLR_LOW: begin
          if (fault_in) begin
            clr_ff <= led_bank_pkg::CLR_IDLE;
          end
        end
        default: begin
          clr_ff <= led_bank_pkg::CLR_IDLE;
        end
      endcase
    end
  end

  assign line_toggle = (clr_ff == led_bank_pkg::CLR_LOW) && fault_in;
  // Without a host nothing toggles the line, so only a chip-activate toggle or reset (power cycle) clears.
  assign clr_latch = line_toggle || act_toggle;

  // Per-channel short latch and open-load deglitch.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_chan
      logic [`OPEN_CNT_W-1:0] time_cnt_ff;  // Cycles of continuous full-on with low headroom.
      logic [`DIM_CNT_W-1:0]  dim_cnt_ff;   // Dimming periods in a row with low headroom.

      // A short is only meaningful while the bank drives the channel; set beats clear.
      assign short_set[gi] = short_detect[gi] && bank[gi/2];

      always_ff @(posedge mclk) begin
        if (rst) begin
          short_lat_ff[gi] <= 1'b0;
        end else if (short_set[gi]) begin
          short_lat_ff[gi] <= 1'b1;
        end else if (clr_latch) begin
          short_lat_ff[gi] <= 1'b0;
        end
      end

      // Open load and short to battery share the headroom comparator and self-clear with it.
      always_ff @(posedge mclk) begin
        if (rst || !headroom_low[gi]) begin
          time_cnt_ff      <= '0;
          dim_cnt_ff       <= '0;
          open_conf_ff[gi] <= 1'b0;
        end else begin
          if (!bank[gi/2]) begin
            time_cnt_ff <= '0;
          end else if (time_cnt_ff == `OPEN_CNT_W'(OPEN_DEG_CYCLES - 1)) begin
            open_conf_ff[gi] <= 1'b1;
          end else begin
            time_cnt_ff <= time_cnt_ff + `OPEN_CNT_W'(1);
          end
          if (bank[gi/2] && !bank_prev_ff[gi/2]) begin
            if (dim_cnt_ff == `OPEN_DIM_CYCLES - 3'h1) begin
              open_conf_ff[gi] <= 1'b1;
            end else begin
              dim_cnt_ff <= dim_cnt_ff + 3'h1;
            end
          end
        end
      end
    end
  endgenerate

  // Thermal shutdown with hysteresis between its hot and cool comparators.
  always_ff @(posedge mclk) begin
    if (rst) begin
      tsd_ff <= 1'b0;
    end else if (temp_shutdown_hot) begin
      tsd_ff <= 1'b1;
    end else if (temp_shutdown_cool) begin
      tsd_ff <= 1'b0;
    end
  end

  // Foldback only asks the analog side for less current; it never touches the fault line.
  always_ff @(posedge mclk) begin
    if (rst) begin
      fold_ff <= 1'b0;
    end else if (temp_foldback_hot) begin
      fold_ff <= 1'b1;
    end else if (temp_foldback_cool) begin
      fold_ff <= 1'b0;
    end
  end

  // Reference short ignores the line toggle: only chip-activate or reset releases it.
  always_ff @(posedge mclk) begin
    if (rst) begin
      refshort_ff <= 1'b0;
    end else if (ref_resistor_short) begin
      refshort_ff <= 1'b1;
    end else if (act_toggle) begin
      refshort_ff <= 1'b0;
    end
  end

  // Level select picks base-only or base-plus-boost reference for every channel.
  always_ff @(posedge mclk) begin
    if (rst) begin
      boost_ff <= 1'b0;
    end else begin
      boost_ff <= level_select;
    end
  end

  assign drive_low = tsd_ff || refshort_ff || (|short_lat_ff) || (|open_conf_ff);

  // Channel gating. A low line with our own pull-down means floating; a high line despite it
  // means someone holds it high, which keeps the healthy strings running.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      nxt_chan[i] = ctrl_ff[`CTRL_ENABLE_BIT] && chip_activate &&
                    bank[i/2] &&
                    !tsd_ff && !refshort_ff &&
                    !short_lat_ff[i] &&
                    (fault_in || open_conf_ff[i]);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      chan_ff <= 8'h00;
    end else begin
      chan_ff <= nxt_chan;
    end
  end

  // Open-drain only: the data is always low and only the enable moves.
  assign fault_out              = 1'b0;
  assign fault_oe_n             = !drive_low;
  assign led_channel_en         = chan_ff;
  assign boost_current_setpoint = boost_ff;
  assign foldback_active        = fold_ff;

  // Interrupt events: each is a single-cycle pulse.
  assign events[`INT_SHORT_BIT]    = |(short_set & ~short_lat_ff);
  assign events[`INT_OPEN_BIT]     = |(open_conf_ff & ~open_prev_ff);
  assign events[`INT_TSD_BIT]      = tsd_ff && !tsd_prev_ff;
  assign events[`INT_FOLD_BIT]     = fold_ff && !fold_prev_ff;
  assign events[`INT_REFSHORT_BIT] = refshort_ff && !ref_prev_ff;
  assign events[`INT_LINE_LOW_BIT] = line_prev_ff && !fault_in;
  assign events[`INT_CLEARED_BIT]  = clr_latch;

  // Write-one-to-clear mask from the low byte of a status write.
  assign w1c = (wr_go && awaddr_ff == `REG_INT_STATUS && wstrb_ff[0]) ?
               wdata_ff[`INT_W-1:0] : '0;

  // Sticky status; an event in the clearing cycle survives.
  always_ff @(posedge mclk) begin
    if (rst) begin
      int_sts_ff <= '0;
    end else begin
      int_sts_ff <= (int_sts_ff & ~w1c) | events;
    end
  end

  assign irq = |(int_sts_ff & int_mask_ff);

  // Write channel: address and data are taken independently and held until both are present.
  assign s_axi_awready = !aw_ff && !s_axi_bvalid;
  assign s_axi_wready  = !w_ff && !s_axi_bvalid;
  assign wr_go         = aw_ff && w_ff && !s_axi_bvalid;

  always_ff @(posedge mclk) begin
    if (rst) begin
      aw_ff     <= 1'b0;
      awaddr_ff <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_ff     <= 1'b1;
      awaddr_ff <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      w_ff     <= 1'b0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_ff     <= 1'b1;
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end else if (wr_go) begin
      w_ff <= 1'b0;
    end
  end

  // Response one cycle after both halves are held; unmapped offsets answer SLVERR.
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= reg_mapped(awaddr_ff) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Writable registers; only byte lanes with a strobe change.
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_ff     <= `CTRL_RESET;
      int_mask_ff <= `INT_MASK_RESET;
    end else if (wr_go && wstrb_ff[0]) begin
      if (awaddr_ff == `REG_CTRL) begin
        ctrl_ff <= {31'h0000_0000, wdata_ff[`CTRL_ENABLE_BIT]};
      end
      if (awaddr_ff == `REG_INT_MASK) begin
        int_mask_ff <= wdata_ff[`INT_W-1:0];
      end
    end
  end

  // Read multiplexer over the mapped registers.
  always_comb begin
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      `REG_CTRL: begin
        rd_word = ctrl_ff;
      end
      `REG_STATE: begin
        rd_word[`ST_LINE_BIT]                   = fault_in;
        rd_word[`ST_DRIVE_BIT]                  = drive_low;
        rd_word[`ST_TSD_BIT]                    = tsd_ff;
        rd_word[`ST_FOLD_BIT]                   = fold_ff;
        rd_word[`ST_REFSHORT_BIT]               = refshort_ff;
        rd_word[`ST_BOOST_BIT]                  = boost_ff;
        rd_word[`ST_SHORT_LSB +: 8]             = short_lat_ff;
        rd_word[`ST_OPEN_LSB +: 8]              = open_conf_ff;
        rd_word[`ST_CHON_LSB +: 8]              = chan_ff;
      end
      `REG_INT_STATUS: begin
        rd_word[`INT_W-1:0] = int_sts_ff;
      end
      `REG_INT_MASK: begin
        rd_word[`INT_W-1:0] = int_mask_ff;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // Read channel: one read at a time, data registered one cycle after the address is taken.
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= reg_mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : led_bank_ctrl

// *** tb/led_bank_ctrl_monitor.sv ***
/*
  Concurrent checks on the ports of the LED bank controller.
  Assumes it is bound to led_bank_ctrl and that mclk is the only clock.
*/
`timescale 1ns/1ps
`include "led_bank_params.svh"
module led_bank_ctrl_monitor (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       dim_bank_input_1,
  input wire logic       level_select,
  input wire logic [7:0] short_detect,
  input wire logic       temp_shutdown_hot,
  input wire logic       ref_resistor_short,
  input wire logic       fault_in,
  input wire logic       fault_out,
  input wire logic       fault_oe_n,
  input wire logic [7:0] led_channel_en,
  input wire logic       boost_current_setpoint,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Both halves of a write accepted at the same edge.
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // A read address accepted.
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // A short caught on channel one while its bank is on.
  sequence short_caught;
    short_detect[0] && dim_bank_input_1;
  endsequence
  bank_gate_a: assert property (!dim_bank_input_1 |=> led_channel_en[1:0] == 2'b00)
    else $error("bank one stayed on with its gate low");
  // The first edge after reset is skipped, since the register still held its reset value.
  boost_follow_a: assert property (!$past(rst) |-> boost_current_setpoint == $past(level_select))
    else $error("boost request does not follow level select");
  line_shut_a: assert property (!fault_in && fault_oe_n |=> led_channel_en == 8'h00)
    else $error("channels stayed on with the shared line low");
  short_pull_a: assert property (short_caught |=> !fault_oe_n ##1 !led_channel_en[0])
    else $error("output short not reported or channel left on");
  tsd_off_a: assert property (temp_shutdown_hot |-> ##2 (led_channel_en == 8'h00 && !fault_oe_n))
    else $error("overtemperature did not shut down");
  ref_short_a: assert property (ref_resistor_short |-> ##2 (led_channel_en == 8'h00 && !fault_oe_n))
    else $error("reference short did not shut down");
  drain_only_a: assert property (fault_out == 1'b0)
    else $error("fault line data driven high");
  write_answer_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response late");
  read_answer_a: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read response late");
endmodule : led_bank_ctrl_monitor

bind led_bank_ctrl led_bank_ctrl_monitor u_mon (.mclk, .rst, .dim_bank_input_1, .level_select, .short_detect,
  .temp_shutdown_hot, .ref_resistor_short, .fault_in, .fault_out, .fault_oe_n, .led_channel_en,
  .boost_current_setpoint, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);

// *** tb/fault_line_host.sv ***
/*
  Model of the host and peer drivers on the shared fault line.
  Assumes host_mode 0 floats, 1 holds high, 2 drives low; the weak pull-up wins when nobody pulls.
*/
`timescale 1ns/1ps
module fault_line_host (
  input wire logic [1:0] host_mode,
  input wire logic       peer_low,
  input wire logic       fault_out,
  input wire logic       fault_oe_n,
  output logic           fault_in
);
  // The host's strong pull-up overrides every pull-down on the line.
  always_comb begin
    if (host_mode == 2'h1) begin
      fault_in = 1'b1;
    end else if (host_mode == 2'h2) begin
      fault_in = 1'b0;
    end else if ((!fault_oe_n && !fault_out) || peer_low) begin
      fault_in = 1'b0;
    end else begin
      fault_in = 1'b1; // Weak pull-up only.
    end
  end
endmodule : fault_line_host

// *** tb/test_led_bank_ctrl.sv ***
/*
  Self-checking bench of the LED bank controller: gating, faults, line toggles and registers.
  Assumes the design, its monitor and fault_line_host are compiled before it.
*/
`timescale 1ns/1ps
module test_led_bank_ctrl;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  dim = 4'hf;
  logic        lvl = 1'b0, act = 1'b1, tsh = 1'b0, tsc = 1'b0, tfh = 1'b0, tfc = 1'b0, rs = 1'b0, peer = 1'b0;
  logic [7:0]  sh = 8'h00, hr = 8'h00, led;
  logic [1:0]  hmode = 2'h1;
  logic [1:0]  bresp, rresp;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, fin, fout, oe_n, irq, boost, fold;
  int          error_cnt = 0, n_tests = 0, cycles = 0;

  always #10 mclk = ~mclk;

  led_bank_ctrl #(.OPEN_DEG_CYCLES(20)) dut (.mclk, .rst, .dim_bank_input_1(dim[0]), .dim_bank_input_2(dim[1]),
    .dim_bank_input_3(dim[2]), .dim_bank_input_4(dim[3]), .level_select(lvl), .chip_activate(act),
    .short_detect(sh), .headroom_low(hr), .temp_shutdown_hot(tsh), .temp_shutdown_cool(tsc),
    .temp_foldback_hot(tfh), .temp_foldback_cool(tfc), .ref_resistor_short(rs), .fault_in(fin),
    .fault_out(fout), .fault_oe_n(oe_n), .led_channel_en(led), .boost_current_setpoint(boost),
    .foldback_active(fold), .irq, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  fault_line_host host (.host_mode(hmode), .peer_low(peer), .fault_out(fout), .fault_oe_n(oe_n), .fault_in(fin));

  // Prints the counts and the verdict, then stops.
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  // A hang is cut short well past the few hundred cycles the sequence needs.
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt = error_cnt + 1;
      conclude();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Waits n edges and lands on the falling edge, where outputs are settled.
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask : cyc

  // Write: address and data offered together, each released once taken.
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) begin ta = 1'b1; awvalid <= 1'b0; end
      if (wready) begin tw = 1'b1; wvalid <= 1'b0; end
    end while (!(ta && tw));
    do @(posedge mclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge mclk); while (rvalid !== 1'b1);
    d = rdata;
    rready <= 1'b0;
  endtask : rd

  // Host pulses the held-high line low and back.
  task automatic host_toggle();
    @(posedge mclk) hmode <= 2'h2;
    cyc(2);
    @(posedge mclk) hmode <= 2'h1;
    cyc(3);
  endtask : host_toggle

  // Main sequence: each step drives at a rising edge and checks at a falling edge, except checks right after a read, which land on a rising edge.
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    cyc(3);
    rd(4'h0, rv);
    chk("ctrl reset", 32'h1, rv);
    rd(4'hc, rv);
    chk("mask reset", 32'h0, rv);
    chk("all on", 32'hff, led);
    for (int b = 0; b < 4; b++) begin
      @(posedge mclk) dim <= 4'hf ^ (4'h1 << b);
      cyc(3);
      chk("bank gate", 32'hff ^ (32'h3 << (2 * b)), led);
    end
    @(posedge mclk) dim <= 4'hf;
    for (int v = 1; v >= 0; v--) begin
      @(posedge mclk) lvl <= v[0];
      cyc(3);
      chk("boost", v, boost);
    end
    @(posedge mclk) tfh <= 1'b1;
    cyc(3);
    chk("foldback on", 32'h1, fold);
    chk("foldback silent", 32'h1, oe_n);
    @(posedge mclk) tfh <= 1'b0;
    @(posedge mclk) tfc <= 1'b1;
    cyc(3);
    chk("foldback off", 32'h0, fold);
    @(posedge mclk) tfc <= 1'b0;
    @(posedge mclk) tsh <= 1'b1;
    cyc(3);
    @(posedge mclk) tsh <= 1'b0;
    cyc(3);
    chk("tsd held", 32'h0, oe_n);
    @(posedge mclk) tsc <= 1'b1;
    cyc(3);
    chk("tsd release", 32'h1, oe_n);
    @(posedge mclk) tsc <= 1'b0;
    @(posedge mclk) hr <= 8'h04;
    cyc(10);
    chk("open deglitch", 32'h1, oe_n);
    cyc(15);
    chk("open pulled", 32'h0, oe_n);
    chk("open held high", 32'hff, led);
    @(posedge mclk) hmode <= 2'h0;
    cyc(3);
    chk("open floating", 32'h04, led);
    @(posedge mclk) hr <= 8'h00;
    cyc(3);
    chk("open release", 32'h1ff, {oe_n, led});
    @(posedge mclk) hr <= 8'h04;
    repeat (14) @(posedge mclk) dim <= dim ^ 4'h2;
    cyc(2);
    chk("open dimmed", 32'h0, oe_n);
    @(posedge mclk) hr <= 8'h00;
    @(posedge mclk) hmode <= 2'h1;
    @(posedge mclk) sh <= 8'h01;
    @(posedge mclk) sh <= 8'h00;
    cyc(3);
    chk("short held high", 32'h0fe, {oe_n, led});
    chk("irq masked", 32'h0, irq);
    wr(4'hc, 32'h1);
    cyc(1);
    chk("irq raised", 32'h1, irq);
    rd(4'h8, rv);
    chk("short status", 32'h1, rv & 32'h1);
    wr(4'h8, 32'h7f);
    cyc(1);
    chk("irq cleared", 32'h0, irq);
    host_toggle();
    chk("toggle clears", 32'h1ff, {oe_n, led});
    @(posedge mclk) hmode <= 2'h0;
    @(posedge mclk) sh <= 8'h01;
    @(posedge mclk) sh <= 8'h00;
    cyc(3);
    chk("short floating", 32'h0, led);
    @(posedge mclk) act <= 1'b0;
    cyc(2);
    @(posedge mclk) act <= 1'b1;
    cyc(3);
    chk("activate clears", 32'h1ff, {oe_n, led});
    @(posedge mclk) hmode <= 2'h1;
    @(posedge mclk) rs <= 1'b1;
    @(posedge mclk) rs <= 1'b0;
    host_toggle();
    chk("ref short kept", 32'h000, {oe_n, led});
    @(posedge mclk) act <= 1'b0;
    @(posedge mclk) act <= 1'b1;
    cyc(3);
    chk("ref short cleared", 32'h1ff, {oe_n, led});
    @(posedge mclk) hmode <= 2'h0;
    @(posedge mclk) peer <= 1'b1;
    cyc(3);
    chk("peer pull", 32'h0, led);
    @(posedge mclk) peer <= 1'b0;
    wr(4'h0, 32'h0);
    cyc(2);
    chk("disabled", 32'h0, led);
    wr(4'h2, 32'h0);
    rd(4'h2, rv);
    chk("slverr", 32'ha, {bresp, rresp});
    conclude();
  end
endmodule : test_led_bank_ctrl
